// >>> ors_top.sv
// Purpose: display state registers of the panel driver with reset init
// Assumes: panel_reset_n synchronous to pclk, apb master keeps protocol
// Notes: supply ordering and waits are the host's duty, not checked here
`timescale 1ns/1ps
`default_nettype none
module ors_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // panel reset and serial input
  input wire logic panel_reset_n,
  input wire logic sclk_en,
  input wire logic sdata,
  // display state
  output logic display_on,
  output logic [7:0] mux_ratio,
  output logic [7:0] start_line,
  output logic [1:0] disp_mode
);
  import ors_pkg::*;

  typedef struct packed {
    logic disp_on;
    logic seg_remap;
    logic com_remap;
    ors_mode_e mode;
    logic [7:0] mux;
    logic [7:0] start;
    logic [7:0] offset;
    logic [7:0] coladdr;
    logic [7:0] master;
    logic [NUM_COLOURS-1:0][7:0] colour;
    logic [31:0] rdata;
  } ors_st_s;

  ors_st_s st_reg, st_next;
  logic [7:0] shift_q;
  logic [2:0] bit_cnt;
  logic byte_done;
  logic [7:0] addr;
  logic access;
  logic [31:0] rd_mux;
  logic [23:0] colour_word;

  assign addr = paddr[7:0];
  // one access cycle per transfer, no wait states
  assign access = psel && penable;

  ors_shift u_shift (
    .pclk(pclk),
    .presetn(presetn),
    .clr(!panel_reset_n),
    .sclk_en(sclk_en),
    .sdata(sdata),
    .shift_q(shift_q),
    .bit_cnt(bit_cnt),
    .byte_done(byte_done)
  );

  // flatten colour contrasts for read-back
  genvar gi;
  generate
    for (gi = 0; gi < NUM_COLOURS; gi++) begin : g_col
      assign colour_word[gi*8 +: 8] = st_reg.colour[gi];
    end
  endgenerate

  // read mux, unmapped reads give zero and no error, pslverr is tied low
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (addr)
      OFF_CTRL: begin
        rd_mux[CTRL_DISP_ON] = st_reg.disp_on;
        rd_mux[CTRL_SEG_REMAP] = st_reg.seg_remap;
        rd_mux[CTRL_COM_REMAP] = st_reg.com_remap;
        rd_mux[CTRL_MODE_LO +: 2] = st_reg.mode;
      end
      OFF_MUX: rd_mux[7:0] = st_reg.mux;
      OFF_START: rd_mux[7:0] = st_reg.start;
      OFF_OFFSET: rd_mux[7:0] = st_reg.offset;
      OFF_COLADDR: rd_mux[7:0] = st_reg.coladdr;
      OFF_MASTER: rd_mux[7:0] = st_reg.master;
      OFF_CONTRAST: rd_mux[23:0] = colour_word;
      OFF_SHIFT: rd_mux[7:0] = shift_q;
      OFF_STATUS: rd_mux[3:0] = {panel_reset_n, bit_cnt};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // next state: panel reset overrides any write
  always_comb begin
    st_next = st_reg;
    if (!panel_reset_n) begin
      st_next.disp_on = 1'b0;
      st_next.mux = RST_MUX;
      st_next.start = RST_START;
      st_next.offset = RST_OFFSET;
      st_next.seg_remap = 1'b0;
      st_next.com_remap = 1'b0;
      st_next.coladdr = RST_COLADDR;
      st_next.master = RST_MASTER;
      for (int i = 0; i < NUM_COLOURS; i++) begin
        st_next.colour[i] = RST_COLOUR;
      end
      st_next.mode = ORS_MODE_NORMAL;
    end else if (access && pwrite) begin
      // a byte finishing under a write still counts, a coladdr write wins
      if (byte_done) begin
        st_next.coladdr = st_reg.coladdr + 8'd1;
      end
      case (addr)
        OFF_CTRL: begin
          st_next.disp_on = pwdata[CTRL_DISP_ON];
          st_next.seg_remap = pwdata[CTRL_SEG_REMAP];
          st_next.com_remap = pwdata[CTRL_COM_REMAP];
          st_next.mode = ors_mode_e'(pwdata[CTRL_MODE_LO +: 2]);
        end
        OFF_MUX: st_next.mux = pwdata[7:0];
        OFF_START: st_next.start = pwdata[7:0];
        OFF_OFFSET: st_next.offset = pwdata[7:0];
        OFF_COLADDR: st_next.coladdr = pwdata[7:0];
        OFF_MASTER: st_next.master = pwdata[7:0];
        OFF_CONTRAST: begin
          for (int i = 0; i < NUM_COLOURS; i++) begin
            st_next.colour[i] = pwdata[i*8 +: 8];
          end
        end
        // unmapped and read-only offsets ignore writes
        default: ;
      endcase
    end else if (byte_done) begin
      // each received byte advances the column counter
      st_next.coladdr = st_reg.coladdr + 8'd1;
    end
    // load in setup so data stands when pready is sampled; one cycle old
    if (psel && !penable && !pwrite) begin
      st_next.rdata = rd_mux;
    end
  end

  // state register, async reset to documented defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{disp_on: 1'b0, seg_remap: 1'b0, com_remap: 1'b0,
                  mode: ORS_MODE_NORMAL, mux: RST_MUX, start: RST_START,
                  offset: RST_OFFSET, coladdr: RST_COLADDR, master: RST_MASTER,
                  colour: {NUM_COLOURS{RST_COLOUR}}, rdata: 32'h0000_0000};
    end else begin
      st_reg <= st_next;
    end
  end

  // zero wait states; read data was loaded at the setup edge
  assign pready = 1'b1;
  assign prdata = st_reg.rdata;
  assign pslverr = 1'b0;
  assign display_on = st_reg.disp_on;
  assign mux_ratio = st_reg.mux;
  assign start_line = st_reg.start;
  assign disp_mode = st_reg.mode;

  // off and 64 rows after reset
  reset_off_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> !display_on && mux_ratio == 8'h40) else $error("display not off");
  start_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> start_line == 8'h00) else $error("start line not zero");
  offset_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> st_reg.offset == 8'h00) else $error("offset not zero");
  map_plain_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> !st_reg.seg_remap && !st_reg.com_remap) else $error("remap set");
  col_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> st_reg.coladdr == 8'h00) else $error("column not zero");
  master_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> st_reg.master == 8'h0F) else $error("master contrast wrong");
  colour_init_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> colour_word == 24'h80_8080) else $error("colour contrast wrong");
  shift_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> bit_cnt == 3'd0 && shift_q == 8'h00) else $error("shift not clear");
  mode_normal_a: assert property (@(posedge pclk) disable iff (!presetn)
    !panel_reset_n |=> disp_mode == 2'd0) else $error("mode not normal");
  col_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    panel_reset_n && byte_done && !(access && pwrite && addr == OFF_COLADDR)
    |=> st_reg.coladdr == 8'($past(st_reg.coladdr) + 8'd1)) else $error("column not advanced");
endmodule
`default_nettype wire

// >>> ors_pkg.sv
// Purpose: shared constants for the panel driver reset-state block
// Assumes: apb slave, 32-bit data, one word per register
// Notes: reset values of the display state live here
package ors_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_MUX = 8'h04;
  localparam logic [7:0] OFF_START = 8'h08;
  localparam logic [7:0] OFF_OFFSET = 8'h0C;
  localparam logic [7:0] OFF_COLADDR = 8'h10;
  localparam logic [7:0] OFF_MASTER = 8'h14;
  localparam logic [7:0] OFF_CONTRAST = 8'h18;
  localparam logic [7:0] OFF_SHIFT = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  // ctrl field positions
  localparam int CTRL_DISP_ON = 0;
  localparam int CTRL_SEG_REMAP = 1;
  localparam int CTRL_COM_REMAP = 2;
  localparam int CTRL_MODE_LO = 4;
  // reset values
  localparam logic [7:0] RST_MUX = 8'h40;
  localparam logic [7:0] RST_START = 8'h00;
  localparam logic [7:0] RST_OFFSET = 8'h00;
  localparam logic [7:0] RST_COLADDR = 8'h00;
  localparam logic [7:0] RST_MASTER = 8'h0F;
  localparam logic [7:0] RST_COLOUR = 8'h80;
  localparam logic [7:0] RST_SHIFT = 8'h00;
  localparam int NUM_COLOURS = 3;
  // display modes, normal is the a4 state
  typedef enum logic [1:0] {
    ORS_MODE_NORMAL,
    ORS_MODE_ALL_ON,
    ORS_MODE_ALL_OFF,
    ORS_MODE_INVERSE
  } ors_mode_e;
endpackage

// >>> ors_shift.sv
// Purpose: serial input shift register with byte assembly
// Assumes: sclk_en is a one-cycle sample pulse in pclk domain
// Notes: cleared by panel reset, partial bits never survive
`timescale 1ns/1ps
`default_nettype none
module ors_shift (
  // clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  // serial input
  input wire logic sclk_en,
  input wire logic sdata,
  // byte output
  output logic [7:0] shift_q,
  output logic [2:0] bit_cnt,
  output logic byte_done
);
  import ors_pkg::*;
  typedef struct packed {
    logic [7:0] sh;
    logic [2:0] cnt;
    logic done;
  } ors_sh_s;
  ors_sh_s st_reg, st_next;

  // shift msb first, flag each full byte
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (clr) begin
      // partial bits dropped on reset
      st_next.sh = RST_SHIFT;
      st_next.cnt = 3'd0;
    end else if (sclk_en) begin
      st_next.sh = {st_reg.sh[6:0], sdata};
      st_next.cnt = st_reg.cnt + 3'd1;
      st_next.done = (st_reg.cnt == 3'd7);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{sh: 8'h00, cnt: 3'd0, done: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign shift_q = st_reg.sh;
  assign bit_cnt = st_reg.cnt;
  assign byte_done = st_reg.done;
endmodule
`default_nettype wire

// >>> ors_host.sv
// Purpose: host model, apb master, supplies and panel reset
// Assumes: pready sampled high at a rising edge ends a transfer
// Notes: long supply settle waits shortened by SETTLE_CYC
`timescale 1ns/1ps
`default_nettype none
module ors_host #(parameter int SETTLE_CYC = 40) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // panel side
  output logic panel_reset_n,
  output logic sclk_en,
  output logic sdata,
  output logic vdd_en,
  output logic vcc_en
);
  import ors_pkg::*;
  // idle at time zero with panel held in reset
  // panel supply disabled, vcc_en driven low
  initial begin
    {psel, penable, pwrite, sclk_en, sdata, vdd_en, vcc_en} = '0;
    paddr = '0;
    pwdata = '0;
    panel_reset_n = 1'b0;
  end
  // one apb transfer; read data taken at the edge that ends the access
  // no request before reset release
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    wait (presetn === 1'b1);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one serial bit; data flips after use so it never looks held
  task automatic send_bit(input logic b);
    @(posedge pclk);
    sclk_en <= 1'b1;
    sdata <= b;
    @(posedge pclk);
    sclk_en <= 1'b0;
    sdata <= ~b;
  endtask
  // panel reset level, changed just after an edge
  // reset used to recover the display
  task automatic panel_hold(input logic v);
    @(posedge pclk);
    panel_reset_n <= v;
  endtask
  // logic on, off, init, clear, panel supply, settle, then on
  task automatic power_up(input logic [7:0] mux);
    logic [31:0] q;
    vdd_en <= 1'b1;
    xfer(1'b1, {24'h0, OFF_CTRL}, 32'h0, q);
    xfer(1'b1, {24'h0, OFF_MUX}, {24'h0, mux}, q);
    repeat (8) send_bit(1'b0);
    vcc_en <= 1'b1;
    repeat (SETTLE_CYC) @(posedge pclk);
    xfer(1'b1, {24'h0, OFF_CTRL}, 32'h1, q);
  endtask
  // off, panel supply off, discharge, logic off
  task automatic power_down();
    logic [31:0] q;
    xfer(1'b1, {24'h0, OFF_CTRL}, 32'h0, q);
    vcc_en <= 1'b0;
    repeat (SETTLE_CYC) @(posedge pclk);
    vdd_en <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
// Purpose: self-checking bench for the panel reset-state block
// Assumes: host model drives all design inputs but pclk and presetn
// Notes: register model kept as ints, compared on every read
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ors_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, panel_reset_n, sclk_en, sdata, display_on;
  logic [31:0] paddr, pwdata, prdata, q;
  logic [31:0] lfsr_q = 32'h0001_01BB;
  logic [7:0] mux_ratio, start_line;
  logic [1:0] disp_mode;
  int err_total = 0;
  int num_checks = 0;
  int exp_reg [9];
  int wmask [9] = '{32'h0000_0037, 32'h0000_00FF, 32'h0000_00FF, 32'h0000_00FF,
    32'h0000_00FF, 32'h0000_00FF, 32'h00FF_FFFF, 0, 0};
  // 4 ns clock
  always #2 pclk = ~pclk;
  // lfsr source of random stimulus
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  ors_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .panel_reset_n(panel_reset_n), .sclk_en(sclk_en), .sdata(sdata),
    .display_on(display_on), .mux_ratio(mux_ratio), .start_line(start_line),
    .disp_mode(disp_mode));
  ors_host #(.SETTLE_CYC(40)) host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .panel_reset_n(panel_reset_n), .sclk_en(sclk_en), .sdata(sdata),
    .vdd_en(), .vcc_en());
  // reference state after either reset
  task automatic model_reset();
    exp_reg = '{0, RST_MUX, RST_START, RST_OFFSET, RST_COLADDR, RST_MASTER,
      {8'h0, RST_COLOUR, RST_COLOUR, RST_COLOUR}, RST_SHIFT, 8};
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // model updated after the transfer, only while panel reset is released
  task automatic wr(input int i, input logic [31:0] d);
    host.xfer(1'b1, 32'(i * 4), d, q);
    if (panel_reset_n === 1'b1 && i < 7) exp_reg[i] = d & wmask[i];
  endtask
  task automatic rd_all();
    for (int i = 0; i < 9; i++) begin
      host.xfer(1'b0, 32'(i * 4), 32'h0, q);
      chk($sformatf("reg%0d", i), q, exp_reg[i]);
    end
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    chk("display_on", {31'h0, display_on}, {31'h0, exp_reg[0][0]});
    chk("mux_ratio", {24'h0, mux_ratio}, exp_reg[1]);
    chk("start_line", {24'h0, start_line}, exp_reg[2]);
    chk("disp_mode", {30'h0, disp_mode}, {30'h0, exp_reg[0][5:4]});
  endtask
  // serial bit with shift, count and column model
  task automatic sbit(input logic b);
    host.send_bit(b);
    exp_reg[7] = ((exp_reg[7] << 1) | b) & 32'hFF;
    if (exp_reg[8][2:0] == 7) begin
      exp_reg[8] = 8;
      exp_reg[4] = (exp_reg[4] + 1) & 32'hFF;
    end else begin
      exp_reg[8]++;
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog, far beyond the expected run
  initial begin
    #200_000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    model_reset();
    exp_reg[8] = 0;
    // defaults while panel reset held low
    rd_all();
    host.panel_hold(1'b1);
    exp_reg[8] = 8;
    $display("test defaults done");
    // random values and every display mode
    for (int n = 0; n < 4; n++) begin
      foreach (wmask[i]) begin
        lfsr_q = lfsr_next(lfsr_q);
        if (wmask[i] != 0) wr(i, (i == 0) ? {lfsr_q[31:6], 2'(n), lfsr_q[3:0]} : lfsr_q);
      end
      rd_all();
    end
    wr(9, 32'h0000_00FF);
    host.xfer(1'b0, 32'h0000_0024, 32'h0, q);
    chk("unmapped", q, 32'h0000_0000);
    $display("test writes done");
    // partial byte, then panel reset mid byte
    for (int n = 0; n < 5; n++) sbit(lfsr_q[n]);
    rd_all();
    host.panel_hold(1'b0);
    wr(1, 32'h0000_0011);
    model_reset();
    exp_reg[8] = 0;
    rd_all();
    host.panel_hold(1'b1);
    exp_reg[8] = 8;
    for (int n = 0; n < 8; n++) sbit(lfsr_q[n + 8]);
    rd_all();
    $display("test serial done");
    // mid-run bus reset brings back the same defaults
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    model_reset();
    rd_all();
    $display("test bus reset done");
    host.power_up(8'h7F);
    exp_reg[0] = 1;
    exp_reg[1] = 32'h7F;
    exp_reg[4]++;
    exp_reg[7] = 0;
    rd_all();
    host.power_down();
    exp_reg[0] = 0;
    rd_all();
    $display("test power done");
    complete_run();
  end
endmodule
`default_nettype wire
